// >>> ppw_map.vh
`ifndef PPW_MAP_VH
`define PPW_MAP_VH
// Program pulse width in ns and derived cycle count at 200 MHz
`define PPW_PULSE_NS      100000
`define PPW_CLK_NS        5
`define PPW_PULSE_CYC     (`PPW_PULSE_NS / `PPW_CLK_NS)
// Setup and hold around strobe edges, in cycles
`define PPW_SETUP_CYC     4
// Write attempts per location
`define PPW_MAX_TRIES     10
`define PPW_PAGE_BYTES    4
`define PPW_LAST_ADDR     17'h0efff
`define PPW_ERASED        8'hff
// Command codes
`define PPW_CMD_READ      2'h0
`define PPW_CMD_BYTE      2'h1
`define PPW_CMD_PAGE      2'h2
`endif

// >>> ppw_writer.v
// Function
// R1: Select strobe high puts the device in standby, data floating.
// R2: Select high, pulse high, read low latches one four-byte page.
// R3: After full page, 0.1 ms low pulse with select and read high.
// R4: After a page write, verify with select and read strobe low.
// R5: Repeat write and verify up to ten times when verify fails.
// R6: Byte write is 0.1 ms pulse with select low, read high.
// R7: Select low, pulse high, read low: device presents stored byte.
// R8: Devices whose pulse pin stays high are not written.
// R9: Read: place address, select read mode, capture data bus byte.
// R10: Erased location reads as all ones.
// R11: Program only addresses 0000h through efffh; page writes check only cmd_addr, not base plus 3.
// R12: Port active only with reset low and supply applied; reads are run with vpp_high low.
// R13: Select low, read high floats the device data bus.
// R14: Data pins float during page write; latch kept until pulse ends.
// R15: Inhibit states float data pins and perform no write.
`timescale 1ns/10ps
`default_nettype none
`include "ppw_map.vh"
module ppw_writer
#(
   parameter PULSE_CYC = `PPW_PULSE_CYC,
   parameter SETUP_CYC = `PPW_SETUP_CYC
)
(
   input  wire        ref_clk,
   input  wire        rstn,
   input  wire        cmd_valid,
   input  wire [1:0]  cmd_op,
   input  wire [16:0] cmd_addr,
   input  wire [31:0] cmd_data,
   output reg         cmd_ready,
   output reg         done,
   output reg         fail,
   output reg  [7:0]  rd_data,
   output reg         erased,
   output reg         target_reset_n,
   output reg         vpp_high,
   output reg         select_n,
   output reg         read_n,
   output reg         program_pulse_n,
   output reg  [16:0] location_pins,
   input  wire [7:0]  byte_bus_pins_in,
   output reg  [7:0]  byte_bus_pins_out,
   output reg         byte_bus_pins_oe
);
   localparam S_IDLE  = 3'h0;
   localparam S_LATCH = 3'h1;
   localparam S_PULSE = 3'h2;
   localparam S_VSET  = 3'h3;
   localparam S_VCHK  = 3'h4;
   localparam S_READ  = 3'h5;
   localparam S_END   = 3'h6;

   reg        rst_s1;
   reg        rst_s2;
   reg [7:0]  bus_s1;
   reg [7:0]  bus_s2;
   reg [2:0]  state;
   reg [1:0]  op;
   reg [16:0] base;
   reg [31:0] data;
   reg [1:0]  idx;
   reg [3:0]  tries;
   reg [31:0] cnt;
   reg        bad;
   wire [7:0] cur_byte = data[{idx, 3'h0} +: 8];

   always @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         rst_s1 <= 1'b0;
         rst_s2 <= 1'b0;
      end
      else
      begin
         rst_s1 <= 1'b1;
         rst_s2 <= rst_s1;
      end
   end

   always @(posedge ref_clk)
   begin
      bus_s1 <= byte_bus_pins_in;
      bus_s2 <= bus_s1;
   end

   always @(posedge ref_clk or negedge rst_s2)
   begin
      if (!rst_s2)
      begin
         state             <= S_IDLE;
         op                <= 2'h0;
         base              <= 17'h00000;
         data              <= 32'h00000000;
         idx               <= 2'h0;
         tries             <= 4'h0;
         cnt               <= 32'h00000000;
         bad               <= 1'b0;
         cmd_ready         <= 1'b0;
         done              <= 1'b0;
         fail              <= 1'b0;
         rd_data           <= 8'h00;
         erased            <= 1'b0;
         target_reset_n    <= 1'b0;
         vpp_high          <= 1'b0;
         select_n          <= 1'b1;
         read_n            <= 1'b1;
         program_pulse_n   <= 1'b1;
         location_pins     <= 17'h00000;
         byte_bus_pins_out <= 8'h00;
         byte_bus_pins_oe  <= 1'b0;
      end
      else
      begin
         done           <= 1'b0;
         target_reset_n <= 1'b0; // R12
         case (state)
            S_IDLE:
            begin
               select_n         <= 1'b1; // R1
               read_n           <= 1'b1;
               program_pulse_n  <= 1'b1; // R8
               byte_bus_pins_oe <= 1'b0;
               cmd_ready        <= 1'b1;
               if (cmd_valid && cmd_ready)
               begin
                  cmd_ready <= 1'b0;
                  op        <= cmd_op;
                  base      <= cmd_addr;
                  data      <= cmd_data;
                  idx       <= 2'h0;
                  tries     <= 4'h0;
                  cnt       <= 32'h00000000;
                  fail      <= 1'b0;
                  bad       <= 1'b0;
                  vpp_high  <= (cmd_op != `PPW_CMD_READ); // R12
                  // R11
                  if (cmd_op != `PPW_CMD_READ && cmd_addr > `PPW_LAST_ADDR)
                  begin
                     fail  <= 1'b1;
                     state <= S_END;
                  end
                  else if (cmd_op == `PPW_CMD_READ)
                     state <= S_READ;
                  else if (cmd_op == `PPW_CMD_PAGE)
                     state <= S_LATCH;
                  else
                     state <= S_PULSE;
               end
            end
            S_LATCH:
            begin
               // Select high, pulse high, read low strobes each byte in
               select_n          <= 1'b1; // R2
               program_pulse_n   <= 1'b1;
               location_pins     <= base + {15'h0000, idx};
               byte_bus_pins_out <= cur_byte;
               byte_bus_pins_oe  <= 1'b1;
               read_n            <= !(cnt >= SETUP_CYC && cnt < 2 * SETUP_CYC); // R2
               if (cnt == 3 * SETUP_CYC)
               begin
                  cnt <= 32'h00000000;
                  idx <= idx + 2'h1;
                  if (idx == `PPW_PAGE_BYTES - 1)
                  begin
                     byte_bus_pins_oe <= 1'b0; // R14
                     read_n           <= 1'b1;
                     state            <= S_PULSE;
                  end
               end
               else
                  cnt <= cnt + 32'h1;
            end
            S_PULSE:
            begin
               read_n   <= 1'b1; // R3 R6
               // Page write needs select high, byte write select low
               select_n <= (op == `PPW_CMD_PAGE); // R3 R6
               if (op == `PPW_CMD_BYTE)
               begin
                  location_pins     <= base;
                  byte_bus_pins_out <= data[7:0];
                  byte_bus_pins_oe  <= 1'b1;
               end
               else
                  byte_bus_pins_oe <= 1'b0; // R14
               program_pulse_n <= !(cnt >= SETUP_CYC && cnt < SETUP_CYC + PULSE_CYC); // R3 R6
               if (cnt == 2 * SETUP_CYC + PULSE_CYC)
               begin
                  cnt   <= 32'h00000000;
                  idx   <= 2'h0;
                  bad   <= 1'b0;
                  tries <= tries + 4'h1;
                  state <= S_VSET;
               end
               else
                  cnt <= cnt + 32'h1;
            end
            S_VSET:
            begin
               // Verify: select and read low, pulse high
               byte_bus_pins_oe <= 1'b0;
               program_pulse_n  <= 1'b1;
               select_n         <= 1'b0; // R4 R7
               read_n           <= 1'b0; // R4 R7
               location_pins    <= base + {15'h0000, idx};
               if (cnt == 2 * SETUP_CYC)
               begin
                  cnt   <= 32'h00000000;
                  state <= S_VCHK;
               end
               else
                  cnt <= cnt + 32'h1;
            end
            S_VCHK:
            begin
               read_n <= 1'b1; // R13
               if (bus_s2 != cur_byte)
                  bad <= 1'b1;
               if (op == `PPW_CMD_BYTE || idx == `PPW_PAGE_BYTES - 1)
               begin
                  idx <= 2'h0;
                  if (!(bad || bus_s2 != cur_byte))
                     state <= S_END;
                  else if (tries == `PPW_MAX_TRIES) // R5
                  begin
                     fail  <= 1'b1;
                     state <= S_END;
                  end
                  else
                     state <= S_PULSE; // R5
               end
               else
               begin
                  idx   <= idx + 2'h1;
                  state <= S_VSET;
               end
            end
            S_READ:
            begin
               location_pins    <= base; // R9
               byte_bus_pins_oe <= 1'b0;
               select_n         <= 1'b0; // R9
               read_n           <= 1'b0; // R9
               if (cnt == 2 * SETUP_CYC)
               begin
                  cnt     <= 32'h00000000;
                  rd_data <= bus_s2;
                  erased  <= (bus_s2 == `PPW_ERASED); // R10
                  state   <= S_END;
               end
               else
                  cnt <= cnt + 32'h1;
            end
            S_END:
            begin
               select_n         <= 1'b1; // R15
               read_n           <= 1'b1;
               program_pulse_n  <= 1'b1;
               byte_bus_pins_oe <= 1'b0;
               vpp_high         <= 1'b0;
               done             <= 1'b1;
               state            <= S_IDLE;
            end
            default:
               state <= S_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

// >>> ppw_writer_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module ppw_writer_assertions #(parameter PULSE_CYC = 20000, parameter SETUP_CYC = 4)
(
   input wire logic        ref_clk, rstn, cmd_valid, cmd_ready, done, fail, erased,
   input wire logic        target_reset_n, vpp_high, select_n, read_n, program_pulse_n, byte_bus_pins_oe,
   input wire logic [1:0]  cmd_op,
   input wire logic [16:0] cmd_addr,
   input wire logic [7:0]  rd_data
);
   logic [15:0] low_cnt;
   always @(posedge ref_clk or negedge rstn)
      if (!rstn)
         low_cnt <= 16'h0000;
      else
         low_cnt <= program_pulse_n ? 16'h0000 : low_cnt + 16'h0001;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   sequence s_bad_wr;
      cmd_valid && cmd_ready && cmd_op != 2'h0 && cmd_addr > 17'h0efff;
   endsequence
   sequence s_refused;
      ##[1:4] (done && fail);
   endsequence
   a_reset_held: assert property (target_reset_n == 1'b0) else $error("device reset released");
   a_pulse_width: assert property ($rose(program_pulse_n) |-> low_cnt == PULSE_CYC)
      else $error("program pulse width wrong");
   a_pulse_strobes: assert property (!program_pulse_n |-> read_n && vpp_high)
      else $error("pulse with read strobe low or supply low");
   a_page_float: assert property (!program_pulse_n && select_n |-> !byte_bus_pins_oe)
      else $error("bus driven during page write");
   a_verify_float: assert property (!select_n && !read_n |-> !byte_bus_pins_oe)
      else $error("bus driven while device outputs");
   a_latch_drive: assert property (select_n && !read_n |-> byte_bus_pins_oe)
      else $error("page latch without data");
   a_bad_addr: assert property (s_bad_wr |-> s_refused) else $error("bad address not refused");
   a_bad_quiet: assert property (s_bad_wr |=> program_pulse_n [*4]) else $error("pulse on refused write");
   a_idle_strobes: assert property (cmd_ready |-> select_n && read_n && program_pulse_n)
      else $error("strobes active in idle");
   a_erased_flag: assert property (done |-> erased == (rd_data == 8'hff)) else $error("erased flag wrong");
endmodule
bind ppw_writer ppw_writer_assertions #(.PULSE_CYC(PULSE_CYC), .SETUP_CYC(SETUP_CYC)) chk_inst
   (.ref_clk(ref_clk), .rstn(rstn), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .done(done), .fail(fail),
    .erased(erased), .target_reset_n(target_reset_n), .vpp_high(vpp_high), .select_n(select_n),
    .read_n(read_n), .program_pulse_n(program_pulse_n), .byte_bus_pins_oe(byte_bus_pins_oe),
    .cmd_op(cmd_op), .cmd_addr(cmd_addr), .rd_data(rd_data));
`default_nettype wire

// >>> ppw_prom_model.sv
`timescale 1ns/10ps
`default_nettype none
module ppw_prom_model #(parameter PULSE_NS = 100000)
(
   input wire logic        reset_n, vpp_high, select_n, read_n, program_pulse_n,
   input wire logic [16:0] location_pins,
   input wire logic [7:0]  bus_in,
   output logic [7:0]      bus_q,
   output logic            bus_oe
);
   logic [7:0]  mem [0:17'h1ffff];
   logic [7:0]  page [0:3];
   logic [16:0] base;
   realtime     t_fall;
   integer      skip = 0;
   integer      i;
   wire         active = !reset_n;
   initial for (i = 0; i < 32'h20000; i = i + 1) mem[i] = 8'hff;
   always @(select_n or read_n or program_pulse_n or location_pins or bus_in)
      if (active && select_n && !read_n && program_pulse_n)
      begin
         page[location_pins[1:0]] = bus_in;
         base = {location_pins[16:2], 2'b00};
      end
   always @(negedge program_pulse_n) t_fall = $realtime;
   // Short pulses, inhibit states and other devices' pulses leave the array alone
   always @(posedge program_pulse_n)
      if (active && vpp_high && read_n && $realtime - t_fall >= PULSE_NS)
         if (skip > 0) skip = skip - 1;
         else if (select_n) for (i = 0; i < 4; i = i + 1) mem[base + i] = page[i];
         else mem[location_pins] = bus_in;
   assign bus_oe = active && !select_n && !read_n && program_pulse_n;
   assign bus_q = mem[location_pins];
endmodule
`default_nettype wire

// >>> ppw_writer_bench.sv
`timescale 1ns/10ps
`default_nettype none
module ppw_writer_bench;
   logic ref_clk = 1'b0, rstn = 1'b0, cmd_valid = 1'b0;
   logic [1:0] cmd_op = 2'h0;
   logic [16:0] cmd_addr = 17'h00000, a;
   logic [31:0] cmd_data = 32'h00000000;
   logic [7:0] last = 8'h00, rd_data, w_out, d_q;
   logic [15:0] rnd = 16'h0048;
   logic [16:0] loc;
   wire cmd_ready, done, fail, erased, trn, vpp, sel_n, rd_n, pgm_n, w_oe, d_oe;
   integer error_cnt = 0, n_checks = 0, cyc = 0, i;
   // Undriven bus toggles so a floating read never matches by luck
   wire [7:0] bus = w_oe ? w_out : d_oe ? d_q : ~last;
   ppw_writer #(.PULSE_CYC(8), .SETUP_CYC(4)) ppw_writer_inst (.ref_clk(ref_clk), .rstn(rstn),
      .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_ready(cmd_ready),
      .done(done), .fail(fail), .rd_data(rd_data), .erased(erased), .target_reset_n(trn), .vpp_high(vpp),
      .select_n(sel_n), .read_n(rd_n), .program_pulse_n(pgm_n), .location_pins(loc),
      .byte_bus_pins_in(bus), .byte_bus_pins_out(w_out), .byte_bus_pins_oe(w_oe));
   ppw_prom_model #(.PULSE_NS(40)) ppw_prom_model_inst (.reset_n(trn), .vpp_high(vpp), .select_n(sel_n),
      .read_n(rd_n), .program_pulse_n(pgm_n), .location_pins(loc), .bus_in(bus), .bus_q(d_q), .bus_oe(d_oe));
   always #2.5 ref_clk = ~ref_clk;
   always @(posedge ref_clk)
   begin
      last <= bus;
      cyc <= cyc + 1;
      if (cyc == 30000)
      begin
         error_cnt = error_cnt + 1;
         results;
      end
   end
   function [15:0] lfsr(input [15:0] s);
      lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function [7:0] lane(input [31:0] d, input integer k);
      lane = d[8 * k +: 8];
   endfunction
   task results;
      begin
         if (error_cnt == 0 && n_checks > 0)
            $display("Result: passed");
         else
            $display("Result: failed");
         $finish;
      end
   endtask
   task check(input [31:0] got, input [31:0] exp);
      begin
         n_checks = n_checks + 1;
         if (got !== exp)
         begin
            error_cnt = error_cnt + 1;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task run(input [1:0] op, input [16:0] ad, input [31:0] d);
      integer k;
      begin
         @(negedge ref_clk);
         while (cmd_ready !== 1'b1) @(negedge ref_clk);
         cmd_valid = 1'b1; cmd_op = op; cmd_addr = ad; cmd_data = d;
         @(negedge ref_clk);
         cmd_valid = 1'b0;
         k = 0;
         while (done !== 1'b1 && k < 3000)
         begin
            @(negedge ref_clk);
            k = k + 1;
         end
         check(k < 3000, 1);
      end
   endtask
   task rd(input [16:0] ad, input [7:0] exp);
      begin
         run(2'h0, ad, 32'h0);
         check(rd_data, exp);
         check(erased, exp == 8'hff);
      end
   endtask
   initial
   begin
      repeat (20) @(posedge ref_clk);
      @(negedge ref_clk) rstn = 1'b1;
      rd(17'h00010, 8'hff);
      run(2'h1, 17'h0efff, 32'h5a); check(fail, 0); rd(17'h0efff, 8'h5a);
      ppw_prom_model_inst.skip = 3;
      run(2'h1, 17'h00123, 32'h3c); check(fail, 0); rd(17'h00123, 8'h3c);
      ppw_prom_model_inst.skip = 10;
      run(2'h1, 17'h00124, 32'h81); check(fail, 1); rd(17'h00124, 8'hff);
      run(2'h1, 17'h0f000, 32'h11); check(fail, 1); rd(17'h0f000, 8'hff);
      run(2'h2, 17'h0effc, 32'h44332211); check(fail, 0);
      for (i = 0; i < 4; i = i + 1) rd(17'h0effc + i, lane(32'h44332211, i));
      for (i = 0; i < 6; i = i + 1)
      begin
         rnd = lfsr(rnd);
         a = {5'h00, rnd[11:0]};
         run(2'h1, a, {24'h0, rnd[15:8]}); rd(a, rnd[15:8]);
         rnd = lfsr(rnd);
         run(2'h2, {a[16:2] ^ 15'h0100, 2'b00}, {rnd, ~rnd});
         rd({a[16:2] ^ 15'h0100, 2'b11}, lane({rnd, ~rnd}, 3));
      end
      results;
   end
endmodule
`default_nettype wire
